// *** csp_core.sv ***
// Serial port shifter, register ports and receive FIFO
`timescale 1ns/10ps

module csp_fifo #(
    parameter int W = 8,
    parameter int D = 16
) (
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    input  wire logic         flush,
    // Fill side
    input  wire logic         in_valid,
    input  wire logic [W-1:0] in_data,
    output logic              in_ready,
    // Drain side
    output logic              out_valid,
    output logic [W-1:0]      out_data,
    input  wire logic         out_ready
);
    localparam int AW = $clog2(D);
    logic [W-1:0] mem [D];
    logic [AW:0]  wr_ptr;
    logic [AW:0]  rd_ptr;

    // Extra pointer bit tells full from empty
    wire full  = (wr_ptr[AW] != rd_ptr[AW]) && (wr_ptr[AW-1:0] == rd_ptr[AW-1:0]);
    wire empty = (wr_ptr == rd_ptr);
    wire push  = in_valid & ~full;
    wire pop   = out_valid & out_ready;
    assign in_ready  = ~full;
    assign out_valid = ~empty;
    assign out_data  = mem[rd_ptr[AW-1:0]];

    // Storage
    always_ff @(posedge clk_sys) begin
        if (push) begin
            mem[wr_ptr[AW-1:0]] <= in_data;
        end
    end

    // Pointers
    always_ff @(posedge clk_sys) begin
        if (!resetn || flush) begin
            wr_ptr <= '0;
            rd_ptr <= '0;
        end else begin
            if (push) begin
                wr_ptr <= wr_ptr + 1'b1;
            end
            if (pop) begin
                rd_ptr <= rd_ptr + 1'b1;
            end
        end
    end
endmodule

module csp_core (
    // Clock and reset
    input  wire logic       clk_sys,
    input  wire logic       resetn,
    // Core port accesses
    input  wire logic [2:0] io_sel,
    input  wire logic       io_wr,
    input  wire logic       io_rd,
    input  wire logic [3:0] io_wdata,
    output logic      [3:0] io_rdata,
    output logic            serial_buffer_interrupt,
    // Serial pins
    input  wire logic       sck_in,
    output logic            sck_out,
    output logic            sck_oe,
    output logic            so_out,
    input  wire logic       si_in
);
    logic [3:0]  serial_control_one;
    logic [3:0]  serial_control_two;
    logic [7:0]  tx_buf;
    logic [7:0]  rx_buf;
    logic        tx_full;
    logic        rx_full;
    logic        wr_hi;
    logic        rd_hi;
    logic        irq_pend;
    csp_pkg::sio_state_e state;
    csp_pkg::sio_state_e next_state;
    logic        sck_m;
    logic        sck_s;
    logic        si_m;
    logic        si_s;
    logic        sck_prev;
    logic        sck_int;
    logic [11:0] div_cnt;
    logic [7:0]  tx_sh;
    logic [7:0]  rx_sh;
    logic [7:0]  rx_word;
    logic        rx_hold;
    logic [3:0]  bit_cnt;
    logic        fifo_in_ready;
    logic        fifo_out_valid;
    logic [7:0]  fifo_out_data;

    // Control field decode
    wire len8      = serial_control_one[csp_pkg::CTRL1_WLEN_BIT];
    wire [1:0] rate = serial_control_one[csp_pkg::CTRL1_RATE_LSB +: 2];
    wire en        = serial_control_two[csp_pkg::CTRL2_EN_BIT];
    wire rx_mode   = serial_control_two[csp_pkg::CTRL2_RM_BIT];
    wire int_clk   = serial_control_two[csp_pkg::CTRL2_INT_BIT];
    wire trail     = serial_control_two[csp_pkg::CTRL2_TRAIL_BIT];
    wire tx_mode   = ~rx_mode | len8;

    // Port strobes
    wire wr_c1 = io_wr & (io_sel == csp_pkg::SEL_CTRL1);
    wire wr_c2 = io_wr & (io_sel == csp_pkg::SEL_CTRL2);
    wire wr_tx = io_wr & (io_sel == csp_pkg::SEL_TXBUF) & tx_mode;
    wire rd_rx = io_rd & (io_sel == csp_pkg::SEL_RXBUF);
    wire mode_chg = (wr_c1 & (io_wdata[csp_pkg::CTRL1_WLEN_BIT] != len8))
                  | (wr_c2 & (io_wdata[csp_pkg::CTRL2_RM_BIT] != rx_mode));

    // Status view
    wire shifting = (state == csp_pkg::ST_SHIFT);
    wire serial_active_flag     = (state != csp_pkg::ST_IDLE) | rx_hold;
    wire [3:0] flags = {serial_active_flag, shifting, rx_full, irq_pend};

    // Internal clock: slower rates are longer half periods
    wire [11:0] half = (rate == 2'h0) ? csp_pkg::HALF_CNT :
                       (rate == 2'h1) ? {csp_pkg::HALF_CNT[10:0], 1'b0} :
                                        {csp_pkg::HALF_CNT[9:0], 2'b00};
    wire run_int = int_clk & shifting;
    wire tick    = run_int & (div_cnt == half - 12'h001);

    // Edge detection on whichever clock drives the shifter
    wire sck_lvl   = int_clk ? sck_int : sck_s;
    wire fall      = sck_prev & ~sck_lvl;
    wire rise      = ~sck_prev & sck_lvl;
    wire lead_rx   = rx_mode & ~len8 & ~trail;
    wire done_edge = lead_rx ? fall : rise;
    wire bit_ev    = shifting & done_edge;
    wire [3:0] wlen_m1 = len8 ? 4'h7 : 4'h3;
    wire word_done = bit_ev & (bit_cnt == wlen_m1);

    // Received word assembly, LSB first into the top
    wire [7:0] rx_new = len8 ? {si_s, rx_sh[7:1]} : {4'h0, si_s, rx_sh[7:5]};
    wire rx_done  = word_done & rx_mode;
    wire in_valid = rx_hold | rx_done;
    wire [7:0] in_data = rx_done ? rx_new : rx_word;

    // Start and resume conditions
    wire tx_ok    = ~tx_mode | tx_full;
    wire start    = en & (tx_ok | ~int_clk);
    wire go       = en & ~rx_hold & tx_ok;
    wire stall    = int_clk & ((tx_mode & ~tx_full) | (rx_mode & ~fifo_in_ready));
    wire cont     = word_done & en & ~stall;
    // An external clock cannot be held, so an enable cleared before the next
    // word's first edge ends the frame without sending a dummy word
    wire ext_abort = ~en & ~int_clk & (bit_cnt == 4'h0) & ~bit_ev;
    wire load     = ((state == csp_pkg::ST_IDLE) & start)
                  | ((state == csp_pkg::ST_WAIT) & go) | cont;
    wire tx_load  = load & tx_mode;
    wire rx_pop   = fifo_out_valid & ~rx_full & ~mode_chg;
    wire irq_ev   = (tx_load & ~rx_mode) | rx_pop;

    // Next state
    always_comb begin
        next_state = state;
        case (state)
            csp_pkg::ST_IDLE: begin
                if (start) begin
                    next_state = csp_pkg::ST_SHIFT;
                end
            end
            csp_pkg::ST_SHIFT: begin
                if (word_done && !en) begin
                    next_state = csp_pkg::ST_IDLE;
                end else if (word_done && stall) begin
                    next_state = csp_pkg::ST_WAIT;
                end else if (ext_abort) begin
                    next_state = csp_pkg::ST_IDLE;
                end
            end
            csp_pkg::ST_WAIT: begin
                if (go) begin
                    next_state = csp_pkg::ST_SHIFT;
                end else if (!en && !rx_hold) begin
                    next_state = csp_pkg::ST_IDLE;
                end
            end
            default: begin
                next_state = csp_pkg::ST_IDLE;
            end
        endcase
    end

    // State register
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            state <= csp_pkg::ST_IDLE;
        end else begin
            state <= next_state;
        end
    end

    // Pin synchronisers; clock pin idles high
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sck_m <= 1'b1;
            sck_s <= 1'b1;
            si_m  <= 1'b0;
            si_s  <= 1'b0;
        end else begin
            sck_m <= sck_in;
            sck_s <= sck_m;
            si_m  <= si_in;
            si_s  <= si_m;
        end
    end

    // Internal clock divider, parked high outside a shift
    always_ff @(posedge clk_sys) begin
        if (!resetn || !run_int) begin
            div_cnt <= 12'h000;
            sck_int <= 1'b1;
        end else if (tick) begin
            div_cnt <= 12'h000;
            sck_int <= ~sck_int;
        end else begin
            div_cnt <= div_cnt + 12'h001;
        end
    end

    // Previous clock level for edge finding
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            sck_prev <= 1'b1;
        end else begin
            sck_prev <= sck_lvl;
        end
    end

    // Bit counter and shift registers
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            bit_cnt <= 4'h0;
            tx_sh   <= 8'h00;
            rx_sh   <= 8'h00;
        end else if (load) begin
            bit_cnt <= 4'h0;
            tx_sh   <= tx_buf;
        end else if (bit_ev) begin
            bit_cnt <= bit_cnt + 4'h1;
            tx_sh   <= {1'b0, tx_sh[7:1]};
            rx_sh   <= {si_s, rx_sh[7:1]};
        end
    end

    // Data out: LSB at load, then each leading edge
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            so_out <= 1'b1;
        end else if (tx_load) begin
            so_out <= tx_buf[0];
        end else if (shifting && tx_mode && fall) begin
            so_out <= tx_sh[0];
        end
    end

    // Word awaiting FIFO space; external clock overwrites on overrun
    always_ff @(posedge clk_sys) begin
        if (!resetn || mode_chg) begin
            rx_hold <= 1'b0;
            rx_word <= 8'h00;
        end else if (rx_done && !fifo_in_ready) begin
            rx_hold <= 1'b1;
            rx_word <= rx_new;
        end else if (rx_hold && fifo_in_ready) begin
            rx_hold <= 1'b0;
        end
    end

    // Command registers
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            serial_control_one <= csp_pkg::CTRL1_RESET;
            serial_control_two <= csp_pkg::CTRL2_RESET;
        end else begin
            if (wr_c1) begin
                serial_control_one <= io_wdata;
            end
            if (wr_c2) begin
                serial_control_two <= io_wdata;
            end
        end
    end

    // Transmit buffer; a write in the load cycle still counts
    always_ff @(posedge clk_sys) begin
        if (!resetn || mode_chg) begin
            tx_buf  <= 8'h00;
            tx_full <= 1'b0;
            wr_hi   <= 1'b0;
        end else begin
            if (tx_load) begin
                tx_full <= 1'b0;
            end
            if (irq_ev) begin
                wr_hi <= 1'b0;
            end
            if (wr_tx && (!len8 || wr_hi)) begin
                tx_full <= 1'b1;
            end
            if (wr_tx && len8 && !wr_hi) begin
                tx_buf[3:0] <= io_wdata;
                wr_hi       <= 1'b1;
            end else if (wr_tx && len8) begin
                tx_buf[7:4] <= io_wdata;
                wr_hi       <= 1'b0;
            end else if (wr_tx) begin
                tx_buf[3:0] <= io_wdata;
            end
        end
    end

    // Receive buffer fed from the FIFO head
    always_ff @(posedge clk_sys) begin
        if (!resetn || mode_chg) begin
            rx_buf  <= 8'h00;
            rx_full <= 1'b0;
            rd_hi   <= 1'b0;
        end else if (rx_pop) begin
            rx_buf  <= fifo_out_data;
            rx_full <= 1'b1;
            rd_hi   <= 1'b0;
        end else if (rd_rx && rx_full) begin
            rd_hi   <= len8 & ~rd_hi;
            rx_full <= len8 & ~rd_hi;
        end
    end

    // Read data, one cycle after the strobe
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            io_rdata <= 4'h0;
        end else if (rd_rx) begin
            io_rdata <= rd_hi ? rx_buf[7:4] : rx_buf[3:0];
        end else if (io_rd && io_sel == csp_pkg::SEL_FLAGS) begin
            io_rdata <= flags;
        end else if (io_rd) begin
            io_rdata <= 4'h0;
        end
    end

    // Interrupt pulse and pending flag; a new request beats the clear
    always_ff @(posedge clk_sys) begin
        if (!resetn) begin
            serial_buffer_interrupt <= 1'b0;
            irq_pend                <= 1'b0;
        end else begin
            serial_buffer_interrupt <= irq_ev;
            if (irq_ev) begin
                irq_pend <= 1'b1;
            end else if (wr_tx || (rd_rx && !rd_hi && !len8) || (rd_rx && rd_hi)) begin
                irq_pend <= 1'b0;
            end
        end
    end

    // Clock pin drive only under the internal source
    assign sck_out = sck_int;
    assign sck_oe  = int_clk;

    csp_fifo #(
        .W (csp_pkg::WORD_W),
        .D (csp_pkg::FIFO_DEPTH)
    ) u_rx_fifo (
        .clk_sys   (clk_sys),
        .resetn    (resetn),
        .flush     (mode_chg),
        .in_valid  (in_valid),
        .in_data   (in_data),
        .in_ready  (fifo_in_ready),
        .out_valid (fifo_out_valid),
        .out_data  (fifo_out_data),
        .out_ready (~rx_full & ~mode_chg)
    );

    // Checks
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!resetn);

    a_idle_clock_high: assert property (!shifting |-> sck_int)
        else $error("internal clock not parked high");
    a_half_period_min: assert property (run_int && $changed(sck_int) && $past(run_int)
        |-> $past(div_cnt) == half - 12'h001)
        else $error("internal clock edge too early");
    a_tx_write_block: assert property (io_wr && io_sel == csp_pkg::SEL_TXBUF
        && !tx_mode && !tx_load && !mode_chg |=> $stable(tx_buf))
        else $error("transmit buffer written outside transmit mode");
    a_load_irq_lsb: assert property (tx_load |=> so_out == $past(tx_buf[0])
        && (serial_buffer_interrupt || $past(rx_mode)))
        else $error("load without interrupt or LSB");
    a_word_length: assert property (shifting |-> bit_cnt <= (len8 ? 4'h7 : 4'h3))
        else $error("bit count beyond word length");
    a_wait_stalls: assert property (state == csp_pkg::ST_WAIT |=> $stable(sck_int) && sck_int)
        else $error("clock runs in wait");
    a_stop_on_clear: assert property (word_done && !en |=> state == csp_pkg::ST_IDLE)
        else $error("did not stop after word");
    a_mode_flush: assert property (mode_chg |=> !tx_full && !rx_full && !rx_hold)
        else $error("mode change kept data");
    a_flag_active: assert property (io_rd && io_sel == csp_pkg::SEL_FLAGS
        && state == csp_pkg::ST_IDLE && !rx_hold |=> io_rdata[3] == 1'b0)
        else $error("active flag stuck");
    a_rx_stall: assert property (rx_done && int_clk && !fifo_in_ready && en
        |=> state == csp_pkg::ST_WAIT)
        else $error("receive overran with internal clock");

    c_tx_word: cover property (tx_load ##[1:1000] word_done);
    c_rx_word: cover property (rx_pop);
    c_wait:    cover property (state == csp_pkg::ST_WAIT);
endmodule

// *** csp_core_tb_top.sv ***
// Self-checking testbench for the clocked serial port control block
`timescale 1ns/10ps
module csp_core_tb_top;
    localparam logic [2:0] CT1 = csp_pkg::SEL_CTRL1;
    localparam logic [2:0] CT2 = csp_pkg::SEL_CTRL2;
    localparam logic [2:0] TXB = csp_pkg::SEL_TXBUF;
    localparam logic [2:0] RXB = csp_pkg::SEL_RXBUF;
    localparam logic [2:0] FLG = csp_pkg::SEL_FLAGS;

    logic       clk_sys;
    logic       resetn;
    logic [2:0] io_sel;
    logic       io_wr;
    logic       io_rd;
    logic [3:0] io_wdata;
    logic [3:0] io_rdata;
    logic       irq;
    logic       sck_out;
    logic       sck_oe;
    logic       so_out;
    logic       ext_sck;
    logic       si_in;
    wire        sck_pin;
    int         miscompares;
    int         checks;
    int         irq_n;
    logic [3:0] v;

    // Clock pin: device drives it only while its enable is high
    assign sck_pin = sck_oe ? sck_out : ext_sck;

    csp_core dut_u (
        .clk_sys                 (clk_sys),
        .resetn                  (resetn),
        .io_sel                  (io_sel),
        .io_wr                   (io_wr),
        .io_rd                   (io_rd),
        .io_wdata                (io_wdata),
        .io_rdata                (io_rdata),
        .serial_buffer_interrupt (irq),
        .sck_in                  (sck_pin),
        .sck_out                 (sck_out),
        .sck_oe                  (sck_oe),
        .so_out                  (so_out),
        .si_in                   (si_in)
    );

    csp_far_end far_u (
        .sck_pin (sck_pin),
        .so_pin  (so_out),
        .ext_sck (ext_sck),
        .si_drv  (si_in)
    );

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Interrupt pulses are one cycle wide, so count them as they pass
    always @(posedge clk_sys)
        if (irq === 1'b1)
            irq_n <= irq_n + 1;

    task automatic check(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            miscompares++;
            $display("ERROR t=%0t seen=%h expected=%h", $time, seen, exp);
        end
    endtask

    task automatic close_out();
        $display("checks=%0d miscompares=%0d", checks, miscompares);
        if (miscompares == 0 && checks > 0)
            $display("Regression OK");
        else
            $display("Regression broken");
        $finish;
    endtask

    task automatic wr(input logic [2:0] sel, input logic [3:0] d);
        @(posedge clk_sys);
        io_sel   <= sel;
        io_wdata <= d;
        io_wr    <= 1'b1;
        @(posedge clk_sys);
        io_wr <= 1'b0;
    endtask

    // Read data is registered on the edge that takes the strobe
    task automatic rd(input logic [2:0] sel, output logic [3:0] d);
        @(posedge clk_sys);
        io_sel <= sel;
        io_rd  <= 1'b1;
        @(posedge clk_sys);
        io_rd <= 1'b0;
        #1;
        d = io_rdata;
    endtask

    // Poll one status flag until low; a stuck port ends the run as a failure
    task automatic wait_clear(input int b);
        int n;
        n = 0;
        v = 4'hF;
        while (v[b] !== 1'b0 && n < 8000) begin
            rd(FLG, v);
            n++;
        end
        if (v[b] !== 1'b0) begin
            miscompares++;
            close_out();
        end
    endtask

    // Wait for the active flag to drop
    task automatic wait_idle();
        wait_clear(3);
    endtask

    initial begin
        resetn      = 1'b0;
        io_sel      = 3'h0;
        io_wr       = 1'b0;
        io_rd       = 1'b0;
        io_wdata    = 4'h0;
        miscompares = 0;
        checks      = 0;
        irq_n       = 0;
        repeat (16) @(posedge clk_sys);
        resetn <= 1'b1;
        rd(FLG, v);
        check({4'h0, v}, 8'h00);
        check({7'h00, sck_out}, 8'h01);

        // Internal clock, 8-bit transmit of one word, then stop
        far_u.arm(8'h00, 1'b0);
        wr(CT1, 4'h4);
        wr(CT2, 4'h2);
        wr(TXB, 4'h5);
        wr(TXB, 4'hA);
        irq_n = 0;
        wr(CT2, 4'hA);
        repeat (8) @(posedge clk_sys);
        rd(FLG, v);
        check({4'h0, v & 4'hC}, 8'h0C);
        check({7'h00, sck_oe}, 8'h01);
        wr(CT2, 4'h2);
        wait_idle();
        check(far_u.got, 8'hA5);
        check(irq_n[7:0], 8'h01);
        check({7'h00, sck_out}, 8'h01);

        // Internal clock, 8-bit transmit with no next word: clock parks in wait
        far_u.arm(8'h00, 1'b0);
        wr(TXB, 4'h3);
        wr(TXB, 4'hC);
        wr(CT2, 4'hA);
        repeat (8) @(posedge clk_sys);
        wait_clear(2);
        check({4'h0, v}, 8'h09);
        check({7'h00, sck_out}, 8'h01);
        check(far_u.got, 8'hC3);
        wr(CT2, 4'h2);
        wait_idle();

        // Simultaneous 8-bit exchange, low nibble first on both sides
        far_u.arm(8'h96, 1'b0);
        wr(CT2, 4'h6);
        wr(TXB, 4'hC);
        wr(TXB, 4'h3);
        irq_n = 0;
        wr(CT2, 4'hE);
        repeat (8) @(posedge clk_sys);
        wr(CT2, 4'h6);
        wait_idle();
        repeat (4) @(posedge clk_sys);
        check(far_u.got, 8'h3C);
        check(irq_n[7:0], 8'h01);
        rd(FLG, v);
        check({7'h00, v[1]}, 8'h01);
        rd(RXB, v);
        check({4'h0, v}, 8'h06);
        rd(RXB, v);
        check({4'h0, v}, 8'h09);

        // External clock, 4-bit receive-only, leading edge, two words
        far_u.arm(8'h7B, 1'b1);
        wr(CT1, 4'h0);
        wr(CT2, 4'h4);
        wr(TXB, 4'hF);
        irq_n = 0;
        wr(CT2, 4'hC);
        check({7'h00, sck_oe}, 8'h00);
        far_u.burst(8);
        repeat (16) @(posedge clk_sys);
        check(irq_n[7:0], 8'h01);
        rd(RXB, v);
        check({4'h0, v}, 8'h0B);
        repeat (8) @(posedge clk_sys);
        check(irq_n[7:0], 8'h02);
        wr(CT2, 4'h4);
        wait_idle();
        rd(FLG, v);
        check({7'h00, v[1]}, 8'h01);
        wr(CT1, 4'h4);
        rd(FLG, v);
        check({7'h00, v[1]}, 8'h00);

        // External clock, 4-bit transmit; next word written before the next shift
        far_u.arm(8'h00, 1'b0);
        wr(CT1, 4'h0);
        wr(CT2, 4'h0);
        wr(TXB, 4'h9);
        irq_n = 0;
        wr(CT2, 4'h8);
        wr(TXB, 4'h6);
        far_u.burst(8);
        wr(CT2, 4'h0);
        wait_idle();
        check(far_u.got, 8'h69);
        check(irq_n[7:0], 8'h03);
        close_out();
    end
endmodule

// *** csp_far_end.sv ***
// Far-side serial device model: clock source, data source and data capture
`timescale 1ns/10ps
module csp_far_end (
    // Pin levels seen on the wires
    input  wire logic sck_pin,
    input  wire logic so_pin,
    // Far-side drive
    output logic      ext_sck,
    output logic      si_drv
);
    logic [7:0] rx_word;
    logic [7:0] got;
    logic [2:0] idx;
    logic       smp_fall;
    int         nfall;

    initial begin
        ext_sck  = 1'b1;
        rx_word  = 8'h00;
        got      = 8'h00;
        idx      = 3'h0;
        smp_fall = 1'b0;
        nfall    = 0;
    end

    // First bit waits on the line before the frame's first edge
    assign si_drv = rx_word[idx];

    // New frame: word to send and the edge the device samples on
    task automatic arm(input logic [7:0] word, input logic fall);
        rx_word  = word;
        smp_fall = fall;
        idx      = 3'h0;
        nfall    = 0;
        got      = 8'h00;
    endtask

    // Clock burst; idles high between frames, phases far above two cycles
    task automatic burst(input int n);
        // Start off the system clock edge so the pin never moves with it
        #3;
        repeat (n) begin
            ext_sck = 1'b0;
            #40;
            ext_sck = 1'b1;
            #40;
        end
    endtask

    // Data moves on the edge away from sampling, so it is steady when taken
    always @(negedge sck_pin) begin
        if (!smp_fall && nfall != 0)
            idx <= idx + 3'h1;
        nfall <= nfall + 1;
    end

    // Capture device output LSB first on rising edges
    always @(posedge sck_pin) begin
        got <= {so_pin, got[7:1]};
        if (smp_fall)
            idx <= idx + 3'h1;
    end
endmodule

// *** csp_pkg.sv ***
// Constants, field positions and state codes for the clocked serial port control block
package csp_pkg;

    // Timing
    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned RATE_MAX_BPS = 93750;
    localparam int unsigned BIT_CYC      = (CLK_HZ + RATE_MAX_BPS - 1) / RATE_MAX_BPS;
    localparam int unsigned HALF_CYC     = (BIT_CYC + 1) / 2;
    localparam logic [11:0] HALF_CNT     = 12'(HALF_CYC);

    // Port selects of the core's port accesses
    localparam logic [2:0] SEL_CTRL1 = 3'h0;
    localparam logic [2:0] SEL_CTRL2 = 3'h1;
    localparam logic [2:0] SEL_TXBUF = 3'h2;
    localparam logic [2:0] SEL_RXBUF = 3'h3;
    localparam logic [2:0] SEL_FLAGS = 3'h4;

    // Field positions
    localparam int CTRL1_WLEN_BIT  = 2;
    localparam int CTRL1_RATE_LSB  = 0;
    localparam int CTRL2_EN_BIT    = 3;
    localparam int CTRL2_RM_BIT    = 2;
    localparam int CTRL2_INT_BIT   = 1;
    localparam int CTRL2_TRAIL_BIT = 0;

    // Reset values
    localparam logic [3:0] CTRL1_RESET = 4'h0;
    localparam logic [3:0] CTRL2_RESET = 4'h0;

    // Receive FIFO shape
    localparam int WORD_W     = 8;
    localparam int FIFO_DEPTH = 16;

    typedef enum logic [2:0] {
        ST_IDLE  = 3'b001,
        ST_SHIFT = 3'b010,
        ST_WAIT  = 3'b100
    } sio_state_e;
endpackage
